// >>> hdl/sfr_top.sv
// Operation
// - four-wire dummy 2/4/6/8 from parameter bits
// - dummy count two after reset
// - 0Ch single-wire: fast read, 32-bit address
// - 0Ch four-wire means burst wrap, not here
// - 3Bh: one-line address, eight dummies, dual data
// - dummy clocks ignore lines; host releases IO0
// - 3Ch single-wire only, dual, 32-bit address
// - 6Bh needs quad enable; data on four lines
// - quad output: eight dummies after address
// - 6Ch single-wire only, quad, 32-bit address
// - BBh: address and data on two lines
// - eight mode bits; low nibble ignored
// - dual I/O mode 10: next cycle skips opcode
// - other mode values: next cycle needs opcode
// - BCh single-wire only, dual I/O, 32-bit
// - EBh quad lines, four dummies single-wire
// - quad I/O only with quad enable set, except with the opcode skip armed
// - quad I/O mode 10: next cycle skips opcode
// - shared opcodes follow current address mode
// - four-wire mode bits count as dummies
// - reads ignored while busy, except with the opcode skip armed
`timescale 1ns/1ps
`default_nettype none
module sfr_top (
  input  wire logic              clk_sys,      // 10 MHz
  input  wire logic              arst_n,       // async reset
  // avalon-mm slave
  input  wire logic [3:0]        address,      // byte address
  input  wire logic              read,         // read strobe
  input  wire logic              write,        // write strobe
  input  wire logic [31:0]       writedata,    // write data
  output logic      [31:0]       readdata,     // read data
  output logic                   waitrequest,  // stall
  // flash link, from another domain
  input  wire logic              cs_n,         // chip select
  input  wire logic              sclk,         // serial clock
  input  wire logic [3:0]        io_in,        // line levels
  output sfr_pkg::sfr_pins_s     pins,         // drive and enables
  // array read port, same clock
  output logic      [31:0]       mem_addr,     // byte address
  input  wire logic [7:0]        mem_data      // byte at mem_addr
);
  import sfr_pkg::*;

  // ========================================================
  // state
  typedef struct packed {
    sfr_state_e st;        // sequencer state
    logic [1:0] s_cs;      // select synchroniser
    logic [1:0] s_ck;      // clock synchroniser
    logic [3:0] s_io0;     // line synchroniser, first
    logic [3:0] s_io1;     // line synchroniser, second
    logic       ck_d;      // previous clock level
    sfr_cmd_s   cmd;       // command in flight
    logic [5:0] cnt;       // clocks left in phase
    logic [7:0] sh;        // mode or data shifter
    logic [3:0] bcnt;      // data bits left in byte
    logic [31:0] addr;     // running address
    logic [7:0] opc;       // opcode shifter
    logic       cont;      // opcode skip armed
    logic       four;      // four_wire_instruction_mode
    logic       addr4;     // four-byte address mode
    logic       qe;        // quad_lines_enable_bit
    logic       busy;      // write cycle running
    logic [1:0] rparam;    // read parameter bits
    sfr_pins_s  pins;      // link outputs
    logic       ack;       // bus answer
    logic [31:0] rdata;    // bus read data
  } sfr_regs_s;

  sfr_regs_s r;       // registered state
  sfr_regs_s next_r;  // next state

  // ========================================================
  // timing notes
  // every link input passes two flops, so an edge of the
  // serial clock is acted on about three system clocks
  // after it happens; each level of the serial clock must
  // last several system clocks or an edge is lost
  // lines are sampled on the detected rise and outputs move
  // after the detected fall, so new data stands for about
  // half a serial period before the host samples it
  // select high always wins over the sequencer: a frame cut
  // short in any phase leaves the lines released and the
  // next frame starts from idle
  // the opcode skip flag survives select high; only a mode
  // byte other than 10 or the reset bit clears it, so a host
  // that loses track must send the all-ones exit pattern
  // mem_data is used in the cycle that mem_addr points at
  // it, so the array port must answer combinationally
  // a partial byte at select high is simply dropped
  // the bus and the link share one next-state copy; the
  // link is evaluated last, so a skip flag set by a mode
  // byte wins over a reset bit written in the same cycle

  // ========================================================
  // helpers
  // clocks needed to move a bit count over some lines
  function automatic logic [5:0] clocks(input logic [5:0] b,
                                        input logic [2:0] l);
    if (l == LN4) begin
      clocks = b >> 2;
    end else if (l == LN2) begin
      clocks = b >> 1;
    end else begin
      clocks = b;
    end
  endfunction : clocks

  // shift sampled lines into the low end
  function automatic logic [31:0] shin(input logic [31:0] v,
                                       input logic [3:0]  io,
                                       input logic [2:0]  l);
    if (l == LN4) begin
      shin = {v[27:0], io};
    end else if (l == LN2) begin
      shin = {v[29:0], io[1:0]};
    end else begin
      shin = {v[30:0], io[0]};
    end
  endfunction : shin

  // opcode decode for the current wire mode
  function automatic sfr_cmd_s dec(input logic [7:0] op,
                                   input logic       four,
                                   input logic       qe,
                                   input logic [1:0] rp);
    sfr_cmd_s c;
    c = '0;
    if (four) begin
      // only 0Bh and EBh read here; 0Ch is burst wrap
      unique case (op)
        OP_FAST: begin
          c = '{1'b1, LN4, LN4, 1'b0, 1'b0,
                {1'b0, rp, 1'b0} + 4'h2};
        end
        OP_QIO: begin
          c = '{qe, LN4, LN4, 1'b0, 1'b1, 4'h0};
        end
        default: begin
          c = '0;
        end
      endcase
    end else begin
      unique case (op)
        OP_FAST:  c = '{1'b1, LN1, LN1, 1'b0, 1'b0, DUMMY_STD};
        OP_FAST4: c = '{1'b1, LN1, LN1, 1'b1, 1'b0, DUMMY_STD};
        OP_DOUT:  c = '{1'b1, LN1, LN2, 1'b0, 1'b0, DUMMY_STD};
        OP_DOUT4: c = '{1'b1, LN1, LN2, 1'b1, 1'b0, DUMMY_STD};
        OP_QOUT:  c = '{qe, LN1, LN4, 1'b0, 1'b0, DUMMY_STD};
        OP_QOUT4: c = '{qe, LN1, LN4, 1'b1, 1'b0, DUMMY_STD};
        OP_DIO:   c = '{1'b1, LN2, LN2, 1'b0, 1'b1, 4'h0};
        OP_DIO4:  c = '{1'b1, LN2, LN2, 1'b1, 1'b1, 4'h0};
        OP_QIO:   c = '{qe, LN4, LN4, 1'b0, 1'b1, DUMMY_QIO};
        default:  c = '0;
      endcase
    end
    dec = c;
  endfunction : dec

  // address clocks for a command in the current mode
  function automatic logic [5:0] alen(input sfr_cmd_s c,
                                      input logic     a4);
    alen = clocks((c.a32 | a4) ? BITS32 : BITS24, c.lines_a);
  endfunction : alen

  // ========================================================
  // next-state logic
  always_comb begin
    logic       rise;     // sampled rising clock edge
    logic       fall;     // sampled falling clock edge
    logic       cs_hi;    // synchronised select high
    logic [3:0] io;       // synchronised lines
    logic [31:0] w;       // shift scratch
    logic [3:0] dm;       // dummies after mode bits
    logic [7:0] byt;      // byte being sent
    sfr_cmd_s   c;        // decoded opcode
    rise  = 1'b0;
    fall  = 1'b0;
    cs_hi = 1'b0;
    io    = '0;
    w     = '0;
    dm    = '0;
    byt   = '0;
    c     = '0;
    next_r = r;

    // synchronisers: first stage read only by the second
    next_r.s_cs = {r.s_cs[0], cs_n};
    next_r.s_ck = {r.s_ck[0], sclk};
    next_r.s_io0 = io_in;
    next_r.s_io1 = r.s_io0;
    next_r.ck_d = r.s_ck[1];
    rise  = r.s_ck[1] & ~r.ck_d;
    fall  = ~r.s_ck[1] & r.ck_d;
    cs_hi = r.s_cs[1];
    io    = r.s_io1;

    // avalon slave: one wait cycle, answer on the next
    // register map: control, read parameter, status, address;
    // status and running address are read-only
    next_r.ack = (read | write) & ~r.ack;
    // reads captured in the wait cycle, stand at the answer
    if (read & ~r.ack) begin
      next_r.rdata = '0;
      unique case (address)
        OFF_CTRL: begin
          next_r.rdata[CB_FOUR]  = r.four;
          next_r.rdata[CB_ADDR4] = r.addr4;
          next_r.rdata[CB_QE]    = r.qe;
          next_r.rdata[CB_BUSY]  = r.busy;
        end
        OFF_RPARAM: next_r.rdata[RP_LO+:2] = r.rparam;
        OFF_STAT: begin
          next_r.rdata[2:0]       = r.st;
          next_r.rdata[ST_CONT]   = r.cont;
          next_r.rdata[ST_OPC+:8] = r.opc;
        end
        OFF_ADDR: next_r.rdata = r.addr;
        default:  next_r.rdata = '0;  // unmapped reads zero
      endcase
    end
    // writes land only at the edge where waitrequest is low
    if (write & r.ack) begin
      unique case (address)
        OFF_CTRL: begin
          next_r.four  = writedata[CB_FOUR];
          next_r.addr4 = writedata[CB_ADDR4];
          next_r.qe    = writedata[CB_QE];
          next_r.busy  = writedata[CB_BUSY];
          if (writedata[CB_RST]) begin
            next_r.rparam = RP_RESET;
            next_r.cont   = 1'b0;
          end
        end
        OFF_RPARAM: next_r.rparam = writedata[RP_LO+:2];
        default: ;  // read-only or unmapped: ignored
      endcase
    end

    // link sequencer
    if (cs_hi) begin
      // select high ends any read and frees the lines
      next_r.st = SFR_IDLE;
      next_r.pins.io_oe_n = 4'hf;
    end else begin
      unique case (r.st)
        SFR_IDLE: begin
          next_r.addr = '0;
          if (r.cont) begin
            // skip armed: address comes first
            next_r.st  = SFR_ADDR;
            next_r.cnt = alen(r.cmd, r.addr4);
          end else begin
            next_r.st  = SFR_OPC;
            next_r.cnt = clocks(BYTE_BITS, r.four ? LN4 : LN1);
          end
        end
        SFR_OPC: if (rise) begin
          w = shin({24'h0, r.opc}, io, r.four ? LN4 : LN1);
          next_r.opc = w[7:0];
          next_r.cnt = r.cnt - 6'h1;
          if (r.cnt == 6'h1) begin
            c = dec(w[7:0], r.four, r.qe, r.rparam);
            next_r.cmd = c;
            if (!c.ok || r.busy) begin
              next_r.st = SFR_IGNORE;
            end else begin
              next_r.st  = SFR_ADDR;
              next_r.cnt = alen(c, r.addr4);
            end
          end
        end
        SFR_ADDR: if (rise) begin
          next_r.addr = shin(r.addr, io, r.cmd.lines_a);
          next_r.cnt  = r.cnt - 6'h1;
          if (r.cnt == 6'h1) begin
            next_r.bcnt = '0;
            if (r.cmd.mode) begin
              next_r.st  = SFR_MODE;
              next_r.cnt = clocks(BYTE_BITS, r.cmd.lines_a);
            end else if (r.cmd.dummy != 4'h0) begin
              next_r.st  = SFR_DUMMY;
              next_r.cnt = {2'h0, r.cmd.dummy};
            end else begin
              next_r.st = SFR_DATA;
            end
          end
        end
        SFR_MODE: if (rise) begin
          w = shin({24'h0, r.sh}, io, r.cmd.lines_a);
          next_r.sh  = w[7:0];
          next_r.cnt = r.cnt - 6'h1;
          if (r.cnt == 6'h1) begin
            // only bits 5:4 matter; low nibble ignored
            next_r.cont = (w[MB_SKIP+:2] == SKIP_CODE);
            // four-wire: mode clocks are part of the dummies
            dm = r.four ? ({1'b0, r.rparam, 1'b0} + 4'h2 - MODE_CLK4)
                        : r.cmd.dummy;
            if (dm != 4'h0) begin
              next_r.st  = SFR_DUMMY;
              next_r.cnt = {2'h0, dm};
            end else begin
              next_r.st = SFR_DATA;
            end
          end
        end
        SFR_DUMMY: if (rise) begin
          // line values are not looked at here
          next_r.cnt = r.cnt - 6'h1;
          if (r.cnt == 6'h1) begin
            next_r.st = SFR_DATA;
          end
        end
        SFR_DATA: if (fall) begin
          // drive on falling edges, msb first
          byt = (r.bcnt == 4'h0) ? mem_data : r.sh;
          if (r.bcnt == 4'h0) begin
            next_r.addr = r.addr + 32'h1;
            next_r.bcnt = 4'h8 - {1'b0, r.cmd.lines_d};
          end else begin
            next_r.bcnt = r.bcnt - {1'b0, r.cmd.lines_d};
          end
          if (r.cmd.lines_d == LN4) begin
            next_r.pins.io_out  = byt[7:4];
            next_r.pins.io_oe_n = 4'h0;
            next_r.sh = {byt[3:0], 4'h0};
          end else if (r.cmd.lines_d == LN2) begin
            next_r.pins.io_out  = {2'h0, byt[7:6]};
            next_r.pins.io_oe_n = 4'hc;
            next_r.sh = {byt[5:0], 2'h0};
          end else begin
            next_r.pins.io_out  = {2'h0, byt[7], 1'b0};
            next_r.pins.io_oe_n = 4'hd;
            next_r.sh = {byt[6:0], 1'b0};
          end
        end
        SFR_IGNORE: ;  // wait for select to rise
        default: next_r.st = SFR_IDLE;
      endcase
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // select and serial clock start at their idle high level
      r <= '{st: SFR_IDLE, s_cs: 2'h3, s_ck: 2'h3, ck_d: 1'b1,
             pins: '{4'h0, 4'hf}, rparam: RP_RESET,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ========================================================
  // outputs
  assign readdata    = r.rdata;
  assign waitrequest = (read | write) & ~r.ack;
  assign pins        = r.pins;
  assign mem_addr    = r.addr;

endmodule : sfr_top
`default_nettype wire

// >>> pkg/sfr_pkg.sv
`default_nettype none
// ==========================================================
// shared constants and types of the fast read sequencer
package sfr_pkg;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;  // mode and gate bits
  localparam logic [3:0] OFF_RPARAM = 4'h4;  // read parameter bits
  localparam logic [3:0] OFF_STAT   = 4'h8;  // sequencer state
  localparam logic [3:0] OFF_ADDR   = 4'hc;  // running address
  // control field positions
  localparam int CB_FOUR  = 0;  // four_wire_instruction_mode
  localparam int CB_ADDR4 = 1;  // four-byte address mode
  localparam int CB_QE    = 2;  // quad_lines_enable_bit
  localparam int CB_BUSY  = 3;  // program or erase running
  localparam int CB_RST   = 4;  // reset instruction, write one
  localparam int RP_LO    = 4;  // read parameter field low bit
  localparam int ST_OPC   = 8;  // status: last opcode low bit
  localparam int ST_CONT  = 4;  // status: opcode skip armed
  // opcodes
  localparam logic [7:0] OP_FAST   = 8'h0b;
  localparam logic [7:0] OP_FAST4  = 8'h0c;
  localparam logic [7:0] OP_DOUT   = 8'h3b;
  localparam logic [7:0] OP_DOUT4  = 8'h3c;
  localparam logic [7:0] OP_QOUT   = 8'h6b;
  localparam logic [7:0] OP_QOUT4  = 8'h6c;
  localparam logic [7:0] OP_DIO    = 8'hbb;
  localparam logic [7:0] OP_DIO4   = 8'hbc;
  localparam logic [7:0] OP_QIO    = 8'heb;
  // line counts, bit counts and clock figures
  localparam logic [2:0] LN1 = 3'h1;
  localparam logic [2:0] LN2 = 3'h2;
  localparam logic [2:0] LN4 = 3'h4;
  localparam logic [5:0] BITS24 = 6'h18;
  localparam logic [5:0] BITS32 = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [3:0] DUMMY_STD = 4'h8;   // single-wire reads
  localparam logic [3:0] DUMMY_QIO = 4'h4;   // quad I/O, single-wire
  localparam logic [3:0] MODE_CLK4 = 4'h2;   // mode byte on four lines
  localparam logic [1:0] RP_RESET  = 2'h0;   // two dummy clocks
  localparam logic [1:0] SKIP_CODE = 2'h2;   // mode bits 5:4 = 10
  localparam int MB_SKIP = 4;                // opcode_skip_select_bits
  // sequencer states
  typedef enum logic [2:0] {
    SFR_IDLE, SFR_OPC, SFR_ADDR, SFR_MODE,
    SFR_DUMMY, SFR_DATA, SFR_IGNORE
  } sfr_state_e;
  // decoded command
  typedef struct packed {
    logic       ok;       // opcode accepted
    logic [2:0] lines_a;  // lines for address and mode
    logic [2:0] lines_d;  // lines for data
    logic       a32;      // fixed 32-bit address
    logic       mode;     // carries continuous_read_mode_bits
    logic [3:0] dummy;    // dummy clocks
  } sfr_cmd_s;
  // link pins toward the host
  typedef struct packed {
    logic [3:0] io_out;   // driven line values
    logic [3:0] io_oe_n;  // low while driving
  } sfr_pins_s;
endpackage : sfr_pkg
`default_nettype wire

// >>> verif/sfr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host controller: select, serial clock, lines
module sfr_host (
  input  wire logic               clk_sys,
  input  wire sfr_pkg::sfr_pins_s pins,
  output logic                    cs_n,
  output logic                    sclk,
  output logic [3:0]              io_in
);
  import sfr_pkg::*;
  logic [3:0] hen = 4'h0; // host drives line
  logic [3:0] hv  = 4'h0; // host line value
  initial {cs_n, sclk, io_in} = 6'h30;
  // wire level; a line nobody drives toggles
  always @(posedge clk_sys)
    io_in <= (hen & hv) | (~hen & ~pins.io_oe_n & pins.io_out)
           | (~hen & pins.io_oe_n & ~io_in);
  // one serial clock: fall and drive, rise, sample at its end
  task automatic tick(input logic [3:0] e, input logic [3:0] v,
                      output logic [3:0] s);
    hen <= e;
    hv <= v;
    sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    s = io_in;
  endtask : tick
  // shift b bits msb first on n lines
  task automatic send(input logic [31:0] d, input int b, input int n);
    logic [3:0] s;
    for (int i = b; i > 0; i -= n) tick(4'((1 << n) - 1), 4'(d >> (i - n)), s);
  endtask : send
  // collect one byte; single data comes on IO1
  task automatic recv(output logic [7:0] d, input int n);
    logic [3:0] s;
    d = 8'h00;
    for (int i = 0; i < 8; i += n) begin
      tick(4'h0, 4'h0, s);
      d = (n == 1) ? {d[6:0], s[1]} : (n == 2) ? {d[5:0], s[1:0]}
                                                : {d[3:0], s};
    end
  endtask : recv
  // released clocks, lines ignored by the device
  task automatic gap(input int n);
    logic [3:0] s;
    repeat (n) tick(4'h0, 4'h0, s);
  endtask : gap
  // select edge, then idle clocks before anything else
  task automatic sel(input logic v);
    hen <= 4'h0;
    cs_n <= v;
    repeat (8) @(posedge clk_sys);
  endtask : sel
endmodule : sfr_host
`default_nettype wire

// >>> verif/sfr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks of the fast read sequencer
module sfr_top_sva (
  input wire logic               clk_sys,
  input wire logic               arst_n,
  input wire logic [3:0]         address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        writedata,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire logic               cs_n,
  input wire logic               sclk,
  input wire sfr_pkg::sfr_pins_s pins
);
  import sfr_pkg::*;
  logic [1:0] rp_q;   // expected read parameter
  logic       qe_q;   // expected quad enable
  logic [3:0] bsy;    // cycles since busy set, 0 when clear
  logic [3:0] rise;   // serial rises in this frame
  logic [3:0] fall;   // cycles since serial fall
  logic       sclk_q; // serial clock one cycle back
  logic       wr_ok;  // a write takes effect
  assign wr_ok = write && !waitrequest;
  // shadows of the written controls and link edge counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {rp_q, qe_q, bsy, rise, fall, sclk_q} <= {7'h0, 4'h0, 4'hf, 1'b1};
    end else begin
      sclk_q <= sclk;
      if (wr_ok && address == OFF_RPARAM) rp_q <= writedata[RP_LO+:2];
      if (wr_ok && address == OFF_CTRL && writedata[CB_RST]) rp_q <= RP_RESET;
      if (wr_ok && address == OFF_CTRL) begin
        qe_q <= writedata[CB_QE];
        bsy  <= {3'h0, writedata[CB_BUSY]};
      end else if (bsy != 4'h0 && bsy != 4'hf) bsy <= bsy + 4'h1;
      fall <= (sclk_q && !sclk) ? 4'h0 : fall + {3'h0, fall != 4'hf};
      rise <= cs_n ? 4'h0 : rise + {3'h0, !sclk_q && sclk && rise != 4'hf};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one cycle");
  a_wait_idle: assert property (!read && !write |-> !waitrequest)
    else $error("stall without request");
  a_rparam_read: assert property (
    read && !waitrequest && address == OFF_RPARAM |-> readdata[5:4] == rp_q)
    else $error("read parameter readback wrong");
  a_unmapped_zero: assert property (
    read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_quiet: assert property (cs_n [*8] |-> pins.io_oe_n == 4'hf)
    else $error("lines driven while deselected");
  a_cmd_quiet: assert property (!cs_n && rise < 4'h8 |-> &pins.io_oe_n)
    else $error("lines driven during command");
  a_oe_legal: assert property (
    pins.io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("illegal enable pattern");
  a_out_fall: assert property (
    !$stable(pins.io_out) && pins.io_oe_n != 4'hf
    && $past(pins.io_oe_n) != 4'hf |-> fall < 4'h6)
    else $error("data changed away from serial fall");
  a_oe_fall: assert property ($fell(pins.io_oe_n[1]) |-> fall < 4'h6)
    else $error("drive began away from serial fall");
  a_busy_quiet: assert property (bsy > 4'h9 |-> pins.io_oe_n == 4'hf)
    else $error("read answered while busy");
  a_quad_gate: assert property (pins.io_oe_n == 4'h0 |-> qe_q)
    else $error("quad drive without quad enable");
endmodule : sfr_top_sva
bind sfr_top sfr_top_sva sva (.clk_sys(clk_sys), .arst_n(arst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .cs_n(cs_n),
  .sclk(sclk), .pins(pins));
`default_nettype wire

// >>> verif/sfr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench of the fast read sequencer
module sfr_top_test;
  import sfr_pkg::*;
  logic clk_sys, arst_n, read, write, cs_n, sclk, waitrequest;
  logic [3:0]  address, io_in;
  logic [31:0] writedata, readdata, mem_addr, rd;
  logic [7:0]  mem_data;
  sfr_pins_s   pins;
  int          mismatches = 0, checks = 0;
  logic        fw = 1'b0; // four-wire opcode phase
  localparam logic [31:0] BASE = 32'hc30340ff; // crosses a byte carry
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  sfr_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .pins(pins), .mem_addr(mem_addr), .mem_data(mem_data));
  sfr_host host (.clk_sys(clk_sys), .pins(pins), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in));
  // array image, a byte per address
  function automatic logic [7:0] img(input logic [31:0] a);
    return a[31:24] ^ a[15:8] ^ a[7:0] ^ 8'h5a;
  endfunction : img
  assign mem_data = img(mem_addr);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // avalon cycle held until waitrequest low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_sys);
    {address, writedata, read, write} <= {a, d, !w, w};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    {read, write} <= 2'b00;
  endtask : av
  task automatic cfg(input logic [31:0] c);
    fw = c[CB_FOUR];
    av(1'b1, OFF_CTRL, c, rd);
  endtask : cfg
  // one read frame: opcode, address, mode, dummies, two bytes
  task automatic fr(input logic [7:0] op, input bit skip, input int al,
    input int ab, input bit md, input logic [7:0] mv, input int dm,
    input int dl, input bit ok);
    logic [7:0]  b;
    logic [31:0] a;
    a = (ab == 24) ? {8'h00, BASE[23:0]} : BASE;
    host.sel(1'b0);
    if (!skip) host.send(32'(op), 8, fw ? 4 : 1);
    host.send(a, ab, al);
    if (md) host.send(32'(mv), 8, al);
    host.gap(dm);
    for (int k = 0; k < 2; k++) begin
      host.recv(b, dl);
      if (ok) chk(32'(b), 32'(img(a + k)));
    end
    chk(32'(pins.io_oe_n), 32'(!ok ? 4'hf : dl == 1 ? 4'hd
                              : dl == 2 ? 4'hc : 4'h0));
    host.sel(1'b1);
  endtask : fr
  initial begin
    {arst_n, read, write} <= 3'h0;
    address <= 4'h0;
    writedata <= 32'h0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    av(1'b0, OFF_RPARAM, 32'h0, rd);
    chk(32'(rd[RP_LO+:2]), 32'(RP_RESET));
    av(1'b0, 4'h2, 32'h0, rd);
    chk(rd, 32'h0);
    cfg(32'h0);
    fr(OP_FAST, 0, 1, 24, 0, 8'h00, 8, 1, 1);
    fr(OP_FAST4, 0, 1, 32, 0, 8'h00, 8, 1, 1);
    fr(OP_DOUT, 0, 1, 24, 0, 8'h00, 8, 2, 1);
    fr(OP_DOUT4, 0, 1, 32, 0, 8'h00, 8, 2, 1);
    fr(OP_QOUT, 0, 1, 24, 0, 8'h00, 8, 4, 0);
    fr(OP_QIO, 0, 4, 24, 1, 8'ha0, 4, 4, 0);
    cfg(32'h4);
    fr(OP_QOUT, 0, 1, 24, 0, 8'h00, 8, 4, 1);
    fr(OP_QOUT4, 0, 1, 32, 0, 8'h00, 8, 4, 1);
    fr(OP_DIO, 0, 2, 24, 1, 8'ha5, 0, 2, 1);
    fr(8'h00, 1, 2, 24, 1, 8'hff, 0, 2, 1);
    fr(OP_DIO, 0, 2, 24, 1, 8'ha0, 0, 2, 1);
    host.sel(1'b0);
    host.send(32'hffff, 16, 1);
    host.sel(1'b1);
    fr(OP_DIO4, 0, 2, 32, 1, 8'h1f, 0, 2, 1);
    fr(OP_QIO, 0, 4, 24, 1, 8'ha0, 4, 4, 1);
    fr(8'h00, 1, 4, 24, 1, 8'ha0, 4, 4, 1);
    host.sel(1'b0);
    host.send(32'hff, 8, 1);
    host.sel(1'b1);
    fr(OP_FAST, 0, 1, 24, 0, 8'h00, 8, 1, 1);
    cfg(32'h6);
    fr(OP_DOUT, 0, 1, 32, 0, 8'h00, 8, 2, 1);
    cfg(32'he);
    fr(OP_FAST, 0, 1, 32, 0, 8'h00, 8, 1, 0);
    cfg(32'h5);
    for (int p = 0; p < 4; p++) begin
      av(1'b1, OFF_RPARAM, 32'(p << RP_LO), rd);
      fr(OP_FAST, 0, 4, 24, 0, 8'h00, 2 + 2 * p, 4, 1);
    end
    fr(OP_QIO, 0, 4, 24, 1, 8'h00, 6, 4, 1);
    fr(OP_FAST4, 0, 4, 32, 0, 8'h00, 8, 4, 0);
    fr(OP_DOUT4, 0, 4, 32, 0, 8'h00, 8, 2, 0);
    cfg(32'h15);
    av(1'b0, OFF_RPARAM, 32'h0, rd);
    chk(32'(rd[RP_LO+:2]), 32'(RP_RESET));
    fr(OP_FAST, 0, 4, 24, 0, 8'h00, 2, 4, 1);
    test_done();
  end
  // watchdog against a hung handshake or frame
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
endmodule : sfr_top_test
`default_nettype wire
